// ---- hw/smx_pkg.sv ----
// constants and types for the receiver input mux and clock control block
// assumes one control port that presents byte-wide register accesses
`default_nettype none
package smx_pkg;
  // register offsets
  localparam logic [7:0] ADDR_CLK_CTRL = 8'h06;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h21;
  localparam logic [7:0] ADDR_CLK_STATUS = 8'h22;
  localparam logic [7:0] ADDR_RX_MODE = 8'h23;
  localparam logic [7:0] ADDR_RX_CS = 8'h25;
  localparam logic [7:0] ADDR_RX_ERR = 8'h26;
  localparam logic [7:0] ADDR_Q_FIRST = 8'h30;
  localparam logic [7:0] ADDR_Q_LAST = 8'h39;
  // clock_source_control fields
  localparam int CLK_SW_MANUAL_EXT = 0;
  localparam int CLK_SW_AUTO = 1;
  localparam int CLK_PLL_REF = 2;
  localparam int CLK_FORCE_LOCK = 3;
  localparam int CLK_REC_OE = 4;
  localparam logic [7:0] CLK_CTRL_MASK = 8'h1f;
  // receiver mode control fields
  localparam int RX_SEL_LO = 0;
  localparam int PT_SEL_LO = 3;
  localparam logic [7:0] RX_MODE_MASK = 8'h3f;
  // clock status fields
  localparam int CST_LOCK = 0;
  localparam int CST_USE_EXT = 1;
  localparam int CST_BUSY = 2;
  localparam int CST_ONELINE_REJ = 3;
  // reset values
  localparam logic [7:0] CLK_CTRL_RST = 8'h10;
  localparam logic [7:0] RX_MODE_RST = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  // stream framing
  localparam logic [4:0] CS_BITS = 5'h10;
  localparam logic [6:0] Q_BITS = 7'h50;
  localparam int Q_BYTES = 10;
  // ratios
  localparam logic [8:0] PLL_RATIO = 9'h100;
  localparam logic [7:0] OSR_SINGLE = 8'h80;
  localparam logic [7:0] OSR_DOUBLE = 8'h40;
  localparam logic [7:0] OSR_QUAD = 8'h20;
  // break-before-make dead time on a master clock change
  localparam int SYS_CLK_MHZ = 50;
  localparam int SW_GAP_NS = 100;
  localparam int SW_GAP_CYC_I = (SW_GAP_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] SW_GAP_CYC = 4'(SW_GAP_CYC_I);
  // one-line mode codes
  localparam logic [1:0] OL_NONE = 2'h0;
  localparam logic [1:0] OL_MODE1 = 2'h1;
  localparam logic [1:0] OL_MODE2 = 2'h2;
  typedef enum logic [1:0] {SPD_SINGLE, SPD_DOUBLE, SPD_QUAD} smx_speed_t;
  typedef enum {SW_RUN, SW_STOP, SW_SWAP, SW_START} smx_sw_state_t;
endpackage
`default_nettype wire

// ---- hw/smx_top.sv ----
// input mux, channel-status / subcode capture and master clock control
// assumes a decoder on the link clock delivering framed bits, an analog
// pll with lock output, and clock gating cells driven by the enables here
`default_nettype none
module smx_top (
  // system
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // control port register access
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // digital audio input pins
  input wire logic [7:0] i_din,
  // mux outputs
  output logic o_rx_stream,
  output logic o_passthrough_output,
  // link side decoder, on the recovered clock
  input wire logic i_link_clk,
  input wire logic i_link_bit_valid,
  input wire logic i_link_block_start,
  input wire logic i_link_cbit,
  input wire logic i_link_q_start,
  input wire logic i_link_ubit,
  input wire logic [7:0] i_link_err,
  // pll and master clock control
  input wire logic i_pll_lock,
  output logic o_pll_clk_en,
  output logic o_ext_clk_en,
  output logic o_mclk_use_ext,
  output logic o_pll_ref_aux,
  output logic [8:0] o_pll_ratio,
  output logic o_recovered_clock_oe,
  // serial port mode
  input wire logic i_port_slave,
  input wire logic [1:0] i_oneline_req,
  input wire smx_pkg::smx_speed_t i_speed_mode,
  output logic [1:0] o_oneline_mode,
  output logic [7:0] o_oversample_ratio,
  // status
  output logic o_non_audio,
  output logic o_int
);
  import smx_pkg::*;

  function automatic logic pick(input logic [7:0] v, input logic [2:0] s);
    pick = v[s];
  endfunction

  // link domain reset, released by two flops on the link clock
  logic lrst1;
  logic link_rst_b;
  always_ff @(posedge i_link_clk) begin
    lrst1 <= i_rst_b;
    link_rst_b <= lrst1;
  end

  // channel status capture
  logic [4:0] cs_cnt;
  logic [15:0] cs_shift;
  logic [15:0] cs_hold;
  logic cs_tgl;
  always_ff @(posedge i_link_clk) begin
    if (!link_rst_b) begin
      cs_cnt <= 5'h1f;
      cs_shift <= 16'h0000;
      cs_hold <= 16'h0000;
      cs_tgl <= 1'b0;
    end else if (i_link_bit_valid && i_link_block_start) begin
      cs_shift <= {i_link_cbit, 15'h0000};
      cs_cnt <= 5'h01;
    end else if (i_link_bit_valid && cs_cnt < CS_BITS) begin
      cs_shift <= {i_link_cbit, cs_shift[15:1]};
      cs_cnt <= cs_cnt + 5'h01;
      if (cs_cnt == CS_BITS - 5'h01) begin
        // hold stays put for a whole block, long enough to cross
        cs_hold <= {i_link_cbit, cs_shift[15:1]};
        cs_tgl <= ~cs_tgl;
      end
    end
  end

  // Q subcode capture, first bit is the msb of byte 0
  logic [6:0] q_cnt;
  logic [79:0] q_shift;
  logic [79:0] q_hold;
  logic q_tgl;
  always_ff @(posedge i_link_clk) begin
    if (!link_rst_b) begin
      q_cnt <= 7'h7f;
      q_shift <= 80'h0;
      q_hold <= 80'h0;
      q_tgl <= 1'b0;
    end else if (i_link_bit_valid && i_link_q_start) begin
      q_shift <= {79'h0, i_link_ubit};
      q_cnt <= 7'h01;
    end else if (i_link_bit_valid && q_cnt < Q_BITS) begin
      q_shift <= {q_shift[78:0], i_link_ubit};
      q_cnt <= q_cnt + 7'h01;
      if (q_cnt == Q_BITS - 7'h01) begin
        q_hold <= {q_shift[78:0], i_link_ubit};
        q_tgl <= ~q_tgl;
      end
    end
  end

  // two-flop synchronisers into the system clock
  localparam int SYN_W = 19;
  logic [SYN_W-1:0] syn1;
  logic [SYN_W-1:0] syn2;
  always_ff @(posedge i_sys_clk) begin
    syn1 <= {i_din, i_link_err, i_pll_lock, cs_tgl, q_tgl};
    syn2 <= syn1;
  end
  logic [7:0] din_s;
  logic [7:0] err_s;
  logic lock_s;
  logic cs_tgl_s;
  logic q_tgl_s;
  assign {din_s, err_s, lock_s, cs_tgl_s, q_tgl_s} = syn2;

  logic cs_tgl_d;
  logic q_tgl_d;
  logic cs_new;
  logic q_new;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      cs_tgl_d <= 1'b0;
      q_tgl_d <= 1'b0;
    end else begin
      cs_tgl_d <= cs_tgl_s;
      q_tgl_d <= q_tgl_s;
    end
  end
  assign cs_new = cs_tgl_s ^ cs_tgl_d;
  assign q_new = q_tgl_s ^ q_tgl_d;

  // register writes
  logic [7:0] clk_ctrl;
  logic [7:0] rx_mode;
  logic [7:0] irq_mask;
  logic wr_clk;
  logic wr_rx;
  logic wr_mask;
  assign wr_clk = i_reg_wr && i_reg_addr == ADDR_CLK_CTRL;
  assign wr_rx = i_reg_wr && i_reg_addr == ADDR_RX_MODE;
  assign wr_mask = i_reg_wr && i_reg_addr == ADDR_IRQ_MASK;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      clk_ctrl <= CLK_CTRL_RST;
      rx_mode <= RX_MODE_RST;
      irq_mask <= IRQ_MASK_RST;
    end else begin
      if (wr_clk) begin
        clk_ctrl <= i_reg_wdata & CLK_CTRL_MASK;
      end
      if (wr_rx) begin
        rx_mode <= i_reg_wdata & RX_MODE_MASK;
      end
      if (wr_mask) begin
        irq_mask <= {7'h00, i_reg_wdata[0]};
      end
    end
  end

  logic [2:0] rx_sel;
  logic [2:0] pt_sel;
  assign rx_sel = rx_mode[RX_SEL_LO +: 3];
  assign pt_sel = rx_mode[PT_SEL_LO +: 3];

  // input mux; registering costs one cycle of latency on the stream
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_rx_stream <= 1'b0;
      o_passthrough_output <= 1'b0;
    end else begin
      o_rx_stream <= pick(din_s, rx_sel);
      o_passthrough_output <= pick(din_s, pt_sel);
    end
  end

  // channel status, errors and subcode captured in the system domain
  logic [7:0] cs_reg;
  logic [7:0] err_reg;
  logic [7:0] q_reg [0:Q_BYTES-1];
  logic q_ready;
  logic rd_err;
  logic rd_irq;
  assign rd_err = i_reg_rd && i_reg_addr == ADDR_RX_ERR;
  assign rd_irq = i_reg_rd && i_reg_addr == ADDR_IRQ_STATUS;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      cs_reg <= 8'h00;
      o_non_audio <= 1'b0;
    end else if (cs_new) begin
      // pro, audio flag, copy, any emphasis, origin bit of byte 1
      cs_reg <= {3'h0, cs_hold[15], |cs_hold[5:3], cs_hold[2:0]};
      o_non_audio <= cs_hold[1];
    end
  end

  // errors are sticky until read; a new error in the read cycle survives
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      err_reg <= 8'h00;
    end else begin
      err_reg <= (rd_err ? 8'h00 : err_reg) | err_s;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < Q_BYTES; gi++) begin : g_q
      always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
          q_reg[gi] <= 8'h00;
        end else if (q_new) begin
          q_reg[gi] <= q_hold[79-8*gi -: 8];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      q_ready <= 1'b0;
      o_int <= 1'b0;
    end else begin
      q_ready <= q_new | (q_ready & ~rd_irq);
      o_int <= (q_new | (q_ready & ~rd_irq)) & irq_mask[0];
    end
  end

  // master clock source selection
  logic lock_eff;
  logic want_ext;
  logic use_ext;
  logic [3:0] gap_cnt;
  smx_sw_state_t sw_state;
  // forcing lock stops the fallback, so only the manual select can still pick the external clock then
  assign lock_eff = lock_s | clk_ctrl[CLK_FORCE_LOCK];
  assign want_ext = clk_ctrl[CLK_SW_MANUAL_EXT] |
                    (clk_ctrl[CLK_SW_AUTO] & ~lock_eff);

  // break before make: both gates shut, swap, then the new one opens
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      sw_state <= SW_RUN;
      use_ext <= 1'b0;
      gap_cnt <= 4'h0;
    end else begin
      case (sw_state)
        SW_RUN: begin
          if (want_ext != use_ext) begin
            sw_state <= SW_STOP;
            gap_cnt <= SW_GAP_CYC;
          end
        end
        SW_STOP: begin
          if (gap_cnt == 4'h1) begin
            sw_state <= SW_SWAP;
          end else begin
            gap_cnt <= gap_cnt - 4'h1;
          end
        end
        SW_SWAP: begin
          use_ext <= want_ext;
          sw_state <= SW_START;
          gap_cnt <= SW_GAP_CYC;
        end
        SW_START: begin
          if (gap_cnt == 4'h1) begin
            sw_state <= SW_RUN;
          end else begin
            gap_cnt <= gap_cnt - 4'h1;
          end
        end
        default: begin
          sw_state <= SW_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_pll_clk_en <= 1'b0;
      o_ext_clk_en <= 1'b0;
      o_mclk_use_ext <= 1'b0;
    end else begin
      o_mclk_use_ext <= use_ext;
      // gates stay shut while stopping and swapping
      o_pll_clk_en <= ~use_ext &
                      (sw_state == SW_RUN || sw_state == SW_START);
      o_ext_clk_en <= use_ext &
                      (sw_state == SW_RUN || sw_state == SW_START);
    end
  end

  // pll reference, ratio and recovered clock pin
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_pll_ref_aux <= 1'b0;
      o_pll_ratio <= PLL_RATIO;
      o_recovered_clock_oe <= 1'b0;
    end else begin
      o_pll_ref_aux <= clk_ctrl[CLK_PLL_REF];
      o_pll_ratio <= PLL_RATIO;
      o_recovered_clock_oe <= clk_ctrl[CLK_REC_OE];
    end
  end

  // serial port mode handling
  logic ol_reject;
  assign ol_reject = i_port_slave && i_oneline_req == OL_MODE2;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_oneline_mode <= OL_NONE;
      o_oversample_ratio <= OSR_SINGLE;
    end else begin
      o_oneline_mode <= ol_reject ? OL_NONE : i_oneline_req;
      case (i_speed_mode)
        SPD_SINGLE: o_oversample_ratio <= OSR_SINGLE;
        SPD_DOUBLE: o_oversample_ratio <= OSR_DOUBLE;
        SPD_QUAD: o_oversample_ratio <= OSR_QUAD;
        default: o_oversample_ratio <= OSR_SINGLE;
      endcase
    end
  end

  // register read
  logic [7:0] next_rdata;
  logic [7:0] q_idx;
  assign q_idx = i_reg_addr - ADDR_Q_FIRST;
  always_comb begin
    next_rdata = 8'h00;
    if (i_reg_addr >= ADDR_Q_FIRST && i_reg_addr <= ADDR_Q_LAST) begin
      next_rdata = q_reg[q_idx[3:0]];
    end else begin
      case (i_reg_addr)
        ADDR_CLK_CTRL: next_rdata = clk_ctrl;
        ADDR_RX_MODE: next_rdata = rx_mode;
        ADDR_IRQ_MASK: next_rdata = irq_mask;
        ADDR_IRQ_STATUS: next_rdata = {7'h00, q_ready};
        ADDR_RX_CS: next_rdata = cs_reg;
        ADDR_RX_ERR: next_rdata = err_reg;
        ADDR_CLK_STATUS: begin
          next_rdata[CST_LOCK] = lock_s;
          next_rdata[CST_USE_EXT] = use_ext;
          next_rdata[CST_BUSY] = sw_state != SW_RUN;
          next_rdata[CST_ONELINE_REJ] = ol_reject;
        end
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= next_rdata;
      end
    end
  end
endmodule
`default_nettype wire

// ---- sim/smx_top_asserts.sv ----
// port assertions for smx_top, one system clock domain
// assumes the bind below; counts from smx_pkg
`default_nettype none
module smx_top_asserts (
  // system
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic o_reg_rvalid,
  // port mode
  input wire logic i_port_slave,
  input wire logic [1:0] i_oneline_req,
  input wire smx_pkg::smx_speed_t i_speed_mode,
  input wire logic [1:0] o_oneline_mode,
  input wire logic [7:0] o_oversample_ratio,
  // master clock control
  input wire logic o_pll_clk_en,
  input wire logic o_ext_clk_en,
  input wire logic o_mclk_use_ext,
  input wire logic o_pll_ref_aux,
  input wire logic o_recovered_clock_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  import smx_pkg::*;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);
  wire logic ctl_wr = i_reg_wr && i_reg_addr == ADDR_CLK_CTRL;
  wire logic wd0 = i_reg_wdata[CLK_SW_MANUAL_EXT];
  wire logic wd2 = i_reg_wdata[CLK_PLL_REF];
  wire logic wd4 = i_reg_wdata[CLK_REC_OE];
  both_en_a:
    assert property (!(o_pll_clk_en && o_ext_clk_en))
    else $error("both master clock enables high");
  swap_gap_a:
    assert property ($changed(o_mclk_use_ext) |->
      !$past(o_pll_clk_en) && !$past(o_ext_clk_en))
    else $error("clock select moved while a source was on");
  rd_ans_a:
    assert property (o_reg_rvalid == $past(i_reg_rd))
    else $error("read answer not one cycle after request");
  os_quad_a:
    assert property ((i_speed_mode == SPD_QUAD) [*2] |=>
      o_oversample_ratio == OSR_QUAD)
    else $error("quad speed ratio wrong");
  os_dbl_a:
    assert property ((i_speed_mode == SPD_DOUBLE) [*2] |=>
      o_oversample_ratio == OSR_DOUBLE)
    else $error("double speed ratio wrong");
  ol_rej_a:
    assert property ((i_port_slave && i_oneline_req == OL_MODE2) [*2]
      |=> o_oneline_mode == OL_NONE)
    else $error("second one-line mode accepted in slave");
  ol_one_a:
    assert property ((i_port_slave && i_oneline_req == OL_MODE1) [*2]
      |=> o_oneline_mode == OL_MODE1)
    else $error("first one-line mode refused in slave");
  oe_fol_a:
    assert property (ctl_wr |-> ##2 o_recovered_clock_oe == $past(wd4, 2))
    else $error("recovered clock drive not following control");
  ref_fol_a:
    assert property (ctl_wr |-> ##2 o_pll_ref_aux == $past(wd2, 2))
    else $error("pll reference not following control");
  ext_bnd_a:
    assert property (ctl_wr && wd0 |-> ##[1:20] o_ext_clk_en)
    else $error("manual switch to external clock too slow");
  cover property ($rose(o_ext_clk_en));
  cover property ($rose(o_pll_clk_en));
  cover property (o_oneline_mode == OL_MODE1);
endmodule
bind smx_top smx_top_asserts u_chk (
  .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rvalid(o_reg_rvalid), .i_port_slave(i_port_slave),
  .i_oneline_req(i_oneline_req), .i_speed_mode(i_speed_mode),
  .o_oneline_mode(o_oneline_mode),
  .o_oversample_ratio(o_oversample_ratio),
  .o_pll_clk_en(o_pll_clk_en), .o_ext_clk_en(o_ext_clk_en),
  .o_mclk_use_ext(o_mclk_use_ext), .o_pll_ref_aux(o_pll_ref_aux),
  .o_recovered_clock_oe(o_recovered_clock_oe));
`default_nettype wire

// ---- sim/smx_link_model.sv ----
// stream decoder model feeding the link side of smx_top
// assumes the caller waits for each task; clock 15 ns
`default_nettype none
module smx_link_model (
  // decoder outputs on the recovered clock
  output logic o_clk,
  output logic o_valid,
  output logic o_start,
  output logic o_cbit,
  output logic o_qstart,
  output logic o_ubit,
  output logic [7:0] o_err
);
  timeunit 1ns;
  timeprecision 100ps;
  logic on = 1'b1;
  initial begin
    {o_clk, o_valid, o_start, o_cbit, o_qstart, o_ubit} = 6'h00;
    o_err = 8'h00;
    #3;
    forever #7.5 o_clk = on & ~o_clk;
  end
  // runs through reset so the link reset sync can clear, then stops
  initial #300 on = 1'b0;
  task automatic idle(input int n);
    repeat (n) @(posedge o_clk);
    #1;
  endtask
  task automatic send(input logic [79:0] d, input int n, input logic q);
    on = 1'b1;
    idle(4);
    for (int i = 0; i < n; i++) begin
      o_valid = 1'b1;
      o_start = !q && i == 0;
      o_qstart = q && i == 0;
      o_cbit = d[i];
      o_ubit = d[n - 1 - i];
      idle(1);
    end
    {o_valid, o_start, o_qstart} = 3'h0;
    // released bit lines must not look like the last bit
    o_cbit = ~o_cbit;
    o_ubit = ~o_ubit;
    idle(4);
    on = 1'b0;
  endtask
  task automatic pulse_err(input logic [7:0] e);
    on = 1'b1;
    idle(4);
    o_err = e;
    idle(3);
    o_err = 8'h00;
    idle(4);
    on = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- sim/test_smx_top.sv ----
// self-checking bench for smx_top with the link model
// assumes smx_pkg and the bound checker are compiled first
`default_nettype none
module test_smx_top;
  timeunit 1ns;
  timeprecision 100ps;
  import smx_pkg::*;
  logic clk, rst_b, wr, rd, rvalid, rxs, pts, lclk, lv, lbs, lcb, lqs;
  logic lub, lock, pen, een, uext, raux, oe, slave, nau, irq;
  logic [7:0] addr, wdata, rdata, din, lerr, osr;
  logic [8:0] ratio;
  logic [1:0] olreq, olm;
  smx_speed_t spd;
  int n_fail = 0;
  int n_tests = 0;
  smx_top dut (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_din(din),
    .o_rx_stream(rxs), .o_passthrough_output(pts), .i_link_clk(lclk),
    .i_link_bit_valid(lv), .i_link_block_start(lbs), .i_link_cbit(lcb),
    .i_link_q_start(lqs), .i_link_ubit(lub), .i_link_err(lerr),
    .i_pll_lock(lock), .o_pll_clk_en(pen), .o_ext_clk_en(een),
    .o_mclk_use_ext(uext), .o_pll_ref_aux(raux), .o_pll_ratio(ratio),
    .o_recovered_clock_oe(oe), .i_port_slave(slave),
    .i_oneline_req(olreq), .i_speed_mode(spd), .o_oneline_mode(olm),
    .o_oversample_ratio(osr), .o_non_audio(nau), .o_int(irq));
  smx_link_model lnk (
    .o_clk(lclk), .o_valid(lv), .o_start(lbs), .o_cbit(lcb),
    .o_qstart(lqs), .o_ubit(lub), .o_err(lerr));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
  endtask
  // answer stands one cycle, so it is judged right after the request
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e,
    input logic [7:0] m);
    tick(1);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    chk(rvalid, 1);
    chk(rdata & m, e);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_reset;
    rd_reg(ADDR_CLK_CTRL, CLK_CTRL_RST, 8'hff);
    rd_reg(ADDR_RX_MODE, 8'h00, 8'hff);
    wr_reg(ADDR_RX_CS, 8'hff);
    rd_reg(ADDR_RX_CS, 8'h00, 8'hff);
    rd_reg(8'h07, 8'h00, 8'hff);
    chk(ratio, PLL_RATIO);
    $display("done reset");
  endtask
  task automatic t_mux;
    for (int n = 0; n < 8; n++) begin
      wr_reg(ADDR_RX_MODE, 8'((7 - n) << 3 | n));
      din = 8'h01 << n;
      tick(4);
      chk(rxs, 1);
      chk(pts, 0);
      din = 8'h80 >> n;
      tick(4);
      chk(rxs, 0);
      chk(pts, 1);
    end
    rd_reg(ADDR_RX_MODE, 8'h07, 8'h3f);
    $display("done mux");
  endtask
  task automatic t_stream;
    lnk.send(80'h8003, 16, 1'b0);
    tick(8);
    chk(nau, 1);
    rd_reg(ADDR_RX_CS, 8'h13, 8'h1f);
    lnk.send(80'h0038, 16, 1'b0);
    tick(8);
    chk(nau, 0);
    rd_reg(ADDR_RX_CS, 8'h08, 8'h1f);
    wr_reg(ADDR_IRQ_MASK, 8'h01);
    lnk.send(80'h00112233445566778899, 80, 1'b1);
    tick(8);
    chk(irq, 1);
    for (int i = 0; i < Q_BYTES; i++)
      rd_reg(ADDR_Q_FIRST + 8'(i), 8'(8'h11 * i), 8'hff);
    rd_reg(ADDR_IRQ_STATUS, 8'h01, 8'h01);
    tick(2);
    chk(irq, 0);
    wr_reg(ADDR_IRQ_MASK, 8'h00);
    lnk.send(80'h1, 80, 1'b1);
    tick(8);
    chk(irq, 0);
    rd_reg(ADDR_Q_LAST, 8'h01, 8'hff);
    lnk.pulse_err(8'ha5);
    tick(4);
    rd_reg(ADDR_RX_ERR, 8'ha5, 8'hff);
    rd_reg(ADDR_RX_ERR, 8'h00, 8'hff);
    $display("done stream");
  endtask
  task automatic wait_en(input logic ext);
    for (int i = 0; i < 40 && (ext ? een : pen) !== 1'b1; i++)
      tick(1);
    chk(een, ext);
    chk(pen, !ext);
    chk(uext, ext);
  endtask
  task automatic t_clk;
    wait_en(1'b0);
    wr_reg(ADDR_CLK_CTRL, 8'h11);
    wait_en(1'b1);
    wr_reg(ADDR_CLK_CTRL, 8'h14);
    wait_en(1'b0);
    chk(raux, 1);
    chk(oe, 1);
    wr_reg(ADDR_CLK_CTRL, 8'h02);
    lock = 1'b0;
    wait_en(1'b1);
    chk(oe, 0);
    lock = 1'b1;
    wait_en(1'b0);
    wr_reg(ADDR_CLK_CTRL, 8'h0a);
    lock = 1'b0;
    tick(30);
    chk(een, 0);
    lock = 1'b1;
    $display("done clock");
  endtask
  task automatic t_port;
    // far-side port clocks are taken as running, synchronous and at
    // legal ratios; the block only sees the resulting mode levels
    slave = 1'b1;
    olreq = OL_MODE2;
    tick(3);
    chk(olm, OL_NONE);
    rd_reg(ADDR_CLK_STATUS, 8'h08, 8'h08);
    olreq = OL_MODE1;
    tick(3);
    chk(olm, OL_MODE1);
    for (int s = 0; s < 3; s++) begin
      spd = smx_speed_t'(s);
      tick(3);
      chk(osr, 8'h80 >> s);
    end
    $display("done port");
  endtask
  initial begin
    {rst_b, wr, rd, slave} = 4'h0;
    {addr, wdata, din} = 24'h000000;
    lock = 1'b1;
    olreq = OL_NONE;
    spd = SPD_SINGLE;
    tick(8);
    rst_b = 1'b1;
    t_reset();
    t_mux();
    t_stream();
    t_clk();
    t_port();
    tally_and_finish();
  end
  initial begin
    #200us;
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
